// file: hdl/dpc_checker.sv
// top of the datapath pattern checker: six channel checkers and registers
// assumes samples come from logic on ref_clk_in, so they are not resynced;
// register port: one-cycle strobes, read data valid only the cycle after
//
// The plain strobed port was chosen for this implementation.
module dpc_checker import dpc_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] ch_sample_in,
   input wire logic [NUM_CH-1:0] ch_valid_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DATA_W-1:0] reg_rdata_out
);
   typedef struct packed {
      logic checker_enable;
      logic error_counter_clear;
      logic polynomial_select;
      logic dac0_expect_inverted;
      logic dac1_expect_inverted;
      logic [SEL_W-1:0] readback_channel_select;
      logic [DATA_W-1:0] rdata;
   } dpc_regs_type;

   dpc_regs_type st_q;
   dpc_regs_type st_d;
   logic [NUM_CH-1:0] good;
   logic [NUM_CH-1:0][CNT_W-1:0] cnt;
   logic dac0_match_flag;
   logic dac1_match_flag;
   logic [CNT_W-1:0] dac0_error_tally;
   logic [CNT_W-1:0] dac1_error_tally;

   for (genvar c = 0; c < NUM_CH; c++) begin : g_lane
      dpc_lane_check u_lane (
         .ref_clk_in(ref_clk_in),
         .rst_in(rst_in),
         .sample_in(ch_sample_in[c]),
         .sample_valid_in(ch_valid_in[c]),
         .enable_in(st_q.checker_enable),
         .poly15_in(st_q.polynomial_select),
         .invert_in(c < CH_PER_DAC ? st_q.dac0_expect_inverted
                                   : st_q.dac1_expect_inverted),
         .clear_in(st_q.error_counter_clear),
         .good_out(good[c]),
         .count_out(cnt[c])
      );
   end

   // readback steering; selector 7 shows nothing, so flags read 0 at reset
   always_comb begin
      logic [SEL_W-1:0] k;
      k = (st_q.readback_channel_select >= SEL_DAC1_BASE)
         ? st_q.readback_channel_select - SEL_DAC1_BASE
         : st_q.readback_channel_select;
      dac0_match_flag = 1'b0;
      dac1_match_flag = 1'b0;
      dac0_error_tally = RST_CNT;
      dac1_error_tally = RST_CNT;
      if (st_q.readback_channel_select == SEL_ALL) begin
         dac0_match_flag = |good[CH_PER_DAC-1:0];
         dac1_match_flag = |good[NUM_CH-1:CH_PER_DAC];
         dac0_error_tally = sat_add(sat_add(cnt[0], cnt[1]), cnt[2]);
         dac1_error_tally = sat_add(sat_add(cnt[3], cnt[4]), cnt[5]);
      end else if (st_q.readback_channel_select < SEL_ALL) begin
         dac0_match_flag = good[k];
         dac1_match_flag = good[k+CH_PER_DAC];
         dac0_error_tally = cnt[k];
         dac1_error_tally = cnt[k+CH_PER_DAC];
      end
   end

   always_comb begin
      st_d = st_q;
      st_d.rdata = RD_ZERO;
      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_CTRL: begin
               st_d.checker_enable = reg_wdata_in[BIT_EN];
               st_d.error_counter_clear = reg_wdata_in[BIT_CLR];
               st_d.polynomial_select = reg_wdata_in[BIT_POLY];
               st_d.dac0_expect_inverted = reg_wdata_in[BIT_INV0];
               st_d.dac1_expect_inverted = reg_wdata_in[BIT_INV1];
            end
            ADDR_SEL: begin
               st_d.readback_channel_select = reg_wdata_in[SEL_W-1:0];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            ADDR_CTRL: begin
               st_d.rdata[BIT_GOOD1] = dac1_match_flag;
               st_d.rdata[BIT_GOOD0] = dac0_match_flag;
               st_d.rdata[BIT_INV1] = st_q.dac1_expect_inverted;
               st_d.rdata[BIT_INV0] = st_q.dac0_expect_inverted;
               st_d.rdata[BIT_POLY] = st_q.polynomial_select;
               st_d.rdata[BIT_CLR] = st_q.error_counter_clear;
               st_d.rdata[BIT_EN] = st_q.checker_enable;
            end
            ADDR_CNT0: st_d.rdata = dac0_error_tally;
            ADDR_CNT1: st_d.rdata = dac1_error_tally;
            ADDR_SEL: st_d.rdata[SEL_W-1:0] = st_q.readback_channel_select;
            default: st_d.rdata = RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_q <= '{checker_enable: RST_EN, error_counter_clear: RST_CLR,
                   polynomial_select: RST_POLY,
                   dac0_expect_inverted: RST_INV0,
                   dac1_expect_inverted: RST_INV1,
                   readback_channel_select: RST_SEL,
                   rdata: RD_ZERO};
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata_out = st_q.rdata;

   // widened sums for the checks: the readback saturates, these never wrap
   logic [CNT_W+1:0] sum_dac0_chk;
   logic [CNT_W+1:0] sum_dac1_chk;
   assign sum_dac0_chk = {2'h0, cnt[0]} + {2'h0, cnt[1]} + {2'h0, cnt[2]};
   assign sum_dac1_chk = {2'h0, cnt[3]} + {2'h0, cnt[4]} + {2'h0, cnt[5]};

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   AST_RESET_SEL: assert property (reg_rd_in && reg_addr_in == ADDR_SEL
      && $past(rst_in, 2) && !$past(reg_wr_in) |=> reg_rdata_out == 8'h07)
      else $error("selector did not reset to seven");
   AST_SEL_DAC0_CH: assert property (reg_rd_in && reg_addr_in == ADDR_CNT0
      && st_q.readback_channel_select == 3'h1 |=> reg_rdata_out == $past(cnt[1]))
      else $error("selector 1 did not show DAC0 channel 1 count");
   AST_SEL_DAC1_CH: assert property (reg_rd_in && reg_addr_in == ADDR_CNT1
      && st_q.readback_channel_select == 3'h4 |=> reg_rdata_out == $past(cnt[4]))
      else $error("selector 4 did not show DAC1 channel 1 count");
   AST_OR_ALL: assert property (reg_rd_in && reg_addr_in == ADDR_CTRL
      && st_q.readback_channel_select == SEL_ALL
      |=> reg_rdata_out[BIT_GOOD0] == $past(|good[2:0])
       && reg_rdata_out[BIT_GOOD1] == $past(|good[5:3]))
      else $error("selector 6 flag is not the OR");
   AST_GOOD_SEL0: assert property (reg_rd_in && reg_addr_in == ADDR_CTRL
      && st_q.readback_channel_select == 3'h0
      |=> reg_rdata_out[BIT_GOOD0] == $past(good[0]))
      else $error("DAC0 flag readback wrong");
   AST_CLEAR_ZERO: assert property (st_q.error_counter_clear ##1
      reg_rd_in && reg_addr_in == ADDR_CNT0 |=> reg_rdata_out == 8'h00)
      else $error("count not zero after clear");
   AST_RD_ONE_CYCLE: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data stood beyond one cycle");

   // register map and steering, seen at the port; reset and write values seen in st_q
   AST_SUM_DAC0: assert property (reg_rd_in && reg_addr_in == ADDR_CNT0
      && st_q.readback_channel_select == SEL_ALL
      |=> reg_rdata_out == ($past(sum_dac0_chk) > CNT_MAX ? CNT_MAX
                            : $past(sum_dac0_chk[CNT_W-1:0])))
      else $error("selector 6 DAC0 count is not the saturated sum");
   AST_SUM_DAC1: assert property (reg_rd_in && reg_addr_in == ADDR_CNT1
      && st_q.readback_channel_select == SEL_ALL
      |=> reg_rdata_out == ($past(sum_dac1_chk) > CNT_MAX ? CNT_MAX
                            : $past(sum_dac1_chk[CNT_W-1:0])))
      else $error("selector 6 DAC1 count is not the saturated sum");
   AST_CTRL_RESET: assert property ($fell(rst_in)
      |-> st_q.checker_enable == RST_EN
       && st_q.error_counter_clear == RST_CLR
       && st_q.polynomial_select == RST_POLY
       && st_q.dac0_expect_inverted == RST_INV0
       && st_q.dac1_expect_inverted == RST_INV1
       && st_q.readback_channel_select == RST_SEL)
      else $error("control fields left reset with wrong values");
   AST_CTRL_WRITE: assert property (reg_wr_in && reg_addr_in == ADDR_CTRL
      |=> st_q.checker_enable == $past(reg_wdata_in[BIT_EN])
       && st_q.error_counter_clear == $past(reg_wdata_in[BIT_CLR])
       && st_q.polynomial_select == $past(reg_wdata_in[BIT_POLY])
       && st_q.dac0_expect_inverted == $past(reg_wdata_in[BIT_INV0])
       && st_q.dac1_expect_inverted == $past(reg_wdata_in[BIT_INV1]))
      else $error("control write did not land");
   AST_SEL_WRITE: assert property (reg_wr_in && reg_addr_in == ADDR_SEL
      |=> st_q.readback_channel_select == $past(reg_wdata_in[SEL_W-1:0]))
      else $error("selector write did not land");
   AST_SEL_RESERVED: assert property (reg_rd_in && reg_addr_in == ADDR_SEL
      |=> reg_rdata_out[DATA_W-1:SEL_W] == '0)
      else $error("selector reserved bits read nonzero");
   AST_SEL7_BLANK: assert property (reg_rd_in && reg_addr_in == ADDR_CTRL
      && st_q.readback_channel_select == RST_SEL
      |=> !reg_rdata_out[BIT_GOOD0] && !reg_rdata_out[BIT_GOOD1])
      else $error("selector 7 showed a match flag");
   AST_GOOD_SEL5: assert property (reg_rd_in && reg_addr_in == ADDR_CTRL
      && st_q.readback_channel_select == 3'h5
      |=> reg_rdata_out[BIT_GOOD0] == $past(good[2])
       && reg_rdata_out[BIT_GOOD1] == $past(good[5]))
      else $error("selector 5 flags do not show channel 2");
   AST_CNT1_SEL0: assert property (reg_rd_in && reg_addr_in == ADDR_CNT1
      && st_q.readback_channel_select == 3'h0 |=> reg_rdata_out == $past(cnt[3]))
      else $error("selector 0 did not show DAC1 channel 0 count");
   AST_CNT0_SEL3: assert property (reg_rd_in && reg_addr_in == ADDR_CNT0
      && st_q.readback_channel_select == 3'h3 |=> reg_rdata_out == $past(cnt[0]))
      else $error("selector 3 did not show DAC0 channel 0 count");
   AST_UNMAPPED_ZERO: assert property (reg_rd_in && (reg_addr_in < ADDR_CTRL
      || reg_addr_in > ADDR_SEL) |=> reg_rdata_out == RD_ZERO)
      else $error("unmapped read returned data");

   COV_MISMATCH: cover property (good[0] ##1 !good[0]);
   COV_CLEAR: cover property (!good[3] ##1 st_q.error_counter_clear ##1 good[3]);
   COV_SUM_READ: cover property (st_q.readback_channel_select == SEL_ALL
      && reg_rd_in && reg_addr_in == ADDR_CNT0);
   COV_SATURATED: cover property (reg_rd_in && reg_addr_in == ADDR_CNT0
      ##1 reg_rdata_out == CNT_MAX);
   COV_POLY15_FAIL: cover property (st_q.polynomial_select && good[1]
      ##1 !good[1]);
endmodule

// file: hdl/dpc_pkg.sv
// constants, register map and shared helpers of the datapath pattern checker
// assumes one sample clock and a plain register port with 9-bit addresses
//
// Overview of operation
// - mode bit picks 7-bit or 15-bit polynomial
// - per-DAC good flag reads 1 while matching
// - mismatch drops flag sticky; clear restores, zeroes counts
// - separate 8-bit error count per DAC, reset zero
// - 3-bit readback selector, resets to seven
// - selector 0-2 and 3-5 alike pick channel 0-2 of both DAC0 and DAC1
// - selector 6: OR of flags, sum of counts
package dpc_pkg;
   localparam int SAMPLE_W = 16;
   localparam int NUM_CH = 6;
   localparam int CH_PER_DAC = 3;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int CNT_W = 8;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 9'h14B;
   localparam logic [ADDR_W-1:0] ADDR_CNT0 = 9'h14C;
   localparam logic [ADDR_W-1:0] ADDR_CNT1 = 9'h14D;
   localparam logic [ADDR_W-1:0] ADDR_SEL = 9'h14E;

   localparam int BIT_EN = 0;
   localparam int BIT_CLR = 1;
   localparam int BIT_POLY = 2;
   localparam int BIT_INV0 = 3;
   localparam int BIT_INV1 = 4;
   localparam int BIT_GOOD0 = 6;
   localparam int BIT_GOOD1 = 7;
   localparam int SEL_W = 3;

   localparam logic RST_EN = 1'h0;
   localparam logic RST_CLR = 1'h0;
   localparam logic RST_POLY = 1'h0;
   localparam logic RST_INV0 = 1'h0;
   localparam logic RST_INV1 = 1'h1;
   localparam logic [SEL_W-1:0] RST_SEL = 3'h7;
   localparam logic [CNT_W-1:0] RST_CNT = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

   localparam logic [SEL_W-1:0] SEL_DAC1_BASE = 3'h3;
   localparam logic [SEL_W-1:0] SEL_ALL = 3'h6;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

   // taps of x^7+x^6+1 and x^15+x^14+1, as bit distances back in the stream
   localparam int TAP7_A = 7;
   localparam int TAP7_B = 6;
   localparam int TAP15_A = 15;
   localparam int TAP15_B = 14;

   // counts saturate rather than wrap, so a long failing run never reads 0
   function automatic logic [CNT_W-1:0] sat_add(
      input logic [CNT_W-1:0] a,
      input logic [CNT_W-1:0] b);
      logic [CNT_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[CNT_W] ? CNT_MAX : s[CNT_W-1:0];
   endfunction
endpackage

// file: hdl/dpc_lane_check.sv
// one channel's pattern checker: self-synchronising on the previous word
// assumes samples arrive on the checker clock, bit 0 the newest bit
module dpc_lane_check import dpc_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [SAMPLE_W-1:0] sample_in,
   input wire logic sample_valid_in,
   input wire logic enable_in,
   input wire logic poly15_in,
   input wire logic invert_in,
   input wire logic clear_in,
   output logic good_out,
   output logic [CNT_W-1:0] count_out
);
   typedef struct packed {
      logic [SAMPLE_W-1:0] prev;
      logic primed;
      logic good;
      logic [CNT_W-1:0] cnt;
   } dpc_lane_type;

   dpc_lane_type st_q;
   dpc_lane_type st_d;
   logic mismatch;

   always_comb begin
      logic [2*SAMPLE_W-1:0] s;
      logic tap;
      s = {st_q.prev, sample_in};
      tap = 1'b0;
      mismatch = 1'b0;
      for (int j = 0; j < SAMPLE_W; j++) begin
         tap = poly15_in ? (s[j+TAP15_A] ^ s[j+TAP15_B])
                         : (s[j+TAP7_A] ^ s[j+TAP7_B]);
         // inverted stream obeys the same recurrence with one extra flip
         mismatch = mismatch | (s[j] ^ tap ^ invert_in);
      end
      st_d = st_q;
      if (!enable_in) begin
         st_d.primed = 1'b0;
      end else if (sample_valid_in) begin
         st_d.prev = sample_in;
         st_d.primed = 1'b1;
         if (st_q.primed && mismatch) begin
            st_d.good = 1'b0;
            st_d.cnt = sat_add(st_q.cnt, 8'h01);
         end
      end
      if (clear_in) begin
         st_d.good = 1'b1;
         st_d.cnt = RST_CNT;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_q <= '{prev: '0, primed: 1'b0, good: 1'b1, cnt: RST_CNT};
      end else begin
         st_q <= st_d;
      end
   end

   assign good_out = st_q.good;
   assign count_out = st_q.cnt;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   AST_STICKY_LOW: assert property (!good_out && !clear_in |=> !good_out)
      else $error("match flag rose without a clear");
   AST_CLEAR_RESTORES: assert property (clear_in |=> good_out && count_out == RST_CNT)
      else $error("clear did not restore flag and count");
   AST_IDLE_WHEN_OFF: assert property (!enable_in && !clear_in
      |=> $stable(count_out) && $stable(good_out))
      else $error("count or flag moved while checker disabled");
   AST_PRBS7_BIT0: assert property (enable_in && sample_valid_in && st_q.primed
      && !poly15_in && !clear_in
      && (sample_in[0] != (sample_in[TAP7_A] ^ sample_in[TAP7_B] ^ invert_in))
      |=> !good_out)
      else $error("7-bit mismatch not flagged");
   AST_PRBS15_BIT0: assert property (enable_in && sample_valid_in && st_q.primed
      && poly15_in && !clear_in
      && (sample_in[0] != (sample_in[TAP15_A] ^ sample_in[TAP15_B] ^ invert_in))
      |=> !good_out)
      else $error("15-bit mismatch not flagged");
endmodule

// file: verif/dpc_pattern_check_control_status_source.sv
// stand-in for the serial-link transmitter feeding pattern words
// assumes the checker's clock; bit 0 of a word is the newest bit
module dpc_pattern_check_control_status_source import dpc_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic poly15_in,
   input wire logic [1:0] invert_in,
   input wire logic [NUM_CH-1:0] corrupt_in,
   output logic [NUM_CH-1:0][SAMPLE_W-1:0] ch_sample_out,
   output logic [NUM_CH-1:0] ch_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] hist_q;
   logic [SAMPLE_W-1:0] nw;

   function automatic logic [SAMPLE_W-1:0] next_word(
      input logic [SAMPLE_W-1:0] prev, input logic p15, input logic inv);
      logic [2*SAMPLE_W-1:0] w;
      w = {prev, 16'h0000};
      for (int j = SAMPLE_W-1; j >= 0; j--) begin
         w[j] = p15 ? w[j+15] ^ w[j+14] ^ inv : w[j+7] ^ w[j+6] ^ inv;
      end
      return w[SAMPLE_W-1:0];
   endfunction

   // a corrupted word becomes the new history, so it costs one error only
   always @(posedge ref_clk_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
         nw = next_word(hist_q[c], poly15_in, invert_in[c/CH_PER_DAC]);
         nw[0] = nw[0] ^ corrupt_in[c];
         if (rst_in) begin
            hist_q[c] <= 16'hACE1;
            ch_sample_out[c] <= 16'h0000;
         end else if (run_in) begin
            hist_q[c] <= nw;
            ch_sample_out[c] <= nw;
         end else begin
            ch_sample_out[c] <= ~ch_sample_out[c];
         end
      end
      ch_valid_out <= {NUM_CH{run_in && !rst_in}};
   end
endmodule

// file: verif/dpc_checker_tb_top.sv
// self-checking bench of the datapath pattern checker
// assumes one 100 MHz clock; pattern comes from dpc_pattern_check_control_status_source
module dpc_checker_tb_top import dpc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] st;
      logic [7:0] c0;
      logic [7:0] c1;
   } dpc_row_type;
   // errors: one on lane 1, two on lane 4, one on lane 5
   localparam dpc_row_type ROWS [8] = '{
      '{8'h00, 8'hD1, 8'h00, 8'h00}, '{8'h01, 8'h11, 8'h01, 8'h02},
      '{8'h02, 8'h51, 8'h00, 8'h01}, '{8'h03, 8'hD1, 8'h00, 8'h00},
      '{8'h04, 8'h11, 8'h01, 8'h02}, '{8'h05, 8'h51, 8'h00, 8'h01},
      '{8'h06, 8'hD1, 8'h01, 8'h03}, '{8'h07, 8'h11, 8'h00, 8'h00}};
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 9'h000;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] samp;
   logic [NUM_CH-1:0] valid;
   logic p15 = 1'b0;
   logic [1:0] inv = 2'b10;
   logic [NUM_CH-1:0] corrupt = 6'h00;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;

   always #5 ref_clk_in = ~ref_clk_in;

   dpc_pattern_check_control_status_source dpc_pattern_check_control_status_source_inst (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .run_in(1'b1), .poly15_in(p15), .invert_in(inv),
      .corrupt_in(corrupt), .ch_sample_out(samp), .ch_valid_out(valid));
   dpc_checker dpc_checker_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .ch_sample_in(samp), .ch_valid_in(valid), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata));

   task automatic results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: read %h, want %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end

   initial begin
      tick(3);
      rst_in <= 1'b0;
      wr(ADDR_CTRL, 8'h11);
      tick(5);
      corrupt <= 6'b110010;
      tick(1);
      corrupt <= 6'b000000;
      tick(3);
      corrupt <= 6'b010000;
      tick(1);
      corrupt <= 6'b000000;
      tick(3);
      foreach (ROWS[i]) begin
         wr(ADDR_SEL, ROWS[i].sel);
         rd_chk(ADDR_SEL, ROWS[i].sel);
         rd_chk(ADDR_CTRL, ROWS[i].st);
         rd_chk(ADDR_CNT0, ROWS[i].c0);
         rd_chk(ADDR_CNT1, ROWS[i].c1);
      end
      // summary view until the 0xFA selector write: selector 7 would blank every flag
      wr(ADDR_SEL, 8'h06);
      // long polynomial, inversion swapped; clear covers the switch-over
      p15 <= 1'b1;
      inv <= 2'b01;
      wr(ADDR_CTRL, 8'h0F);
      wr(ADDR_CTRL, 8'h0D);
      tick(40);
      rd_chk(ADDR_CTRL, 8'hCD);
      // dac0 sent plain while inverted is expected: every word fails
      inv <= 2'b00;
      tick(300);
      inv <= 2'b01;
      tick(5);
      rd_chk(ADDR_CTRL, 8'h8D);
      rd_chk(ADDR_CNT0, 8'hFF);
      rd_chk(ADDR_CNT1, 8'h00);
      wr(ADDR_CTRL, 8'h0F);
      rd_chk(ADDR_CTRL, 8'hCF);
      rd_chk(ADDR_CNT0, 8'h00);
      wr(ADDR_CTRL, 8'h0C);
      inv <= 2'b10;
      tick(50);
      rd_chk(ADDR_CNT0, 8'h00);
      rd_chk(ADDR_CTRL, 8'hCC);
      wr(ADDR_SEL, 8'hFA);
      rd_chk(ADDR_SEL, 8'h02);
      wr(ADDR_CTRL, 8'hE0);
      rd_chk(ADDR_CTRL, 8'hC0);
      wr(9'h150, 8'hFF);
      rd_chk(9'h150, 8'h00);
      rst_in <= 1'b1;
      tick(3);
      rst_in <= 1'b0;
      rd_chk(ADDR_SEL, 8'h07);
      rd_chk(ADDR_CTRL, 8'h10);
      rd_chk(ADDR_CNT0, 8'h00);
      rd_chk(ADDR_CNT1, 8'h00);
      results();
   end
endmodule
